// *** design/fault_detect_pkg.sv ***
// Constants of the fault detection and filtering unit.
// Assumes a single 20 MHz device clock and a 16-bit register port.
`default_nettype none

package fault_detect_pkg;

    // Clock and timing
    localparam int unsigned CLK_HZ        = 20_000_000;
    localparam int unsigned SCAN_BASE_MS  = 16;
    localparam int unsigned SCAN_BASE_CYC = SCAN_BASE_MS * (CLK_HZ / 1000);
    localparam int unsigned OSC_WIN_US    = 100;
    localparam int unsigned OSC_WIN_CYC   = OSC_WIN_US * (CLK_HZ / 1_000_000);
    localparam int unsigned SCAN_CODE_MAX = 12;

    // Register addresses
    localparam logic [3:0] ADDR_FAULT_SETUP = 4'h0;
    localparam logic [3:0] ADDR_SCAN_CMD    = 4'h1;
    localparam logic [3:0] ADDR_STATUS      = 4'h2;
    localparam logic [3:0] ADDR_OV_BITS     = 4'h3;
    localparam logic [3:0] ADDR_UV_BITS     = 4'h4;
    localparam logic [3:0] ADDR_OT_BITS     = 4'h5;
    localparam logic [3:0] ADDR_OW_BITS     = 4'h6;
    localparam logic [3:0] ADDR_OSC_LIMITS  = 4'h7;

    // Fault setup fields
    localparam int unsigned SETUP_W       = 13;
    localparam int unsigned SCAN_SEL_LSB  = 0;
    localparam int unsigned WIRE_SEL_BIT  = 4;
    localparam int unsigned TOT_SEL_LSB   = 5;
    localparam int unsigned INT_TEMP_BIT  = 8;
    localparam logic [12:0] SETUP_RESET   = 13'h0000;

    // Scan command bits
    localparam int unsigned CMD_SCAN_VOLT = 0;
    localparam int unsigned CMD_MEASURE   = 1;
    localparam int unsigned CMD_SCAN_TEMP = 2;
    localparam int unsigned CMD_SCAN_WIRE = 3;
    localparam int unsigned CMD_SCAN_ALL  = 4;
    localparam int unsigned CMD_CONT_GO   = 5;
    localparam int unsigned CMD_CONT_STOP = 6;

    // Fault status bit positions
    localparam int unsigned ST_OV   = 0;
    localparam int unsigned ST_UV   = 1;
    localparam int unsigned ST_OT   = 2;
    localparam int unsigned ST_OW   = 3;
    localparam int unsigned ST_VBAT = 4;
    localparam int unsigned ST_VSS  = 5;
    localparam int unsigned ST_OSC  = 6;
    localparam int unsigned ST_REG  = 7;

    // Oscillator edge count limits per window
    localparam logic [7:0] OSC_LO_RESET = 8'h01;
    localparam logic [7:0] OSC_HI_RESET = 8'hFE;

    // Continuous scan state
    typedef enum logic [0:0] {
        SCAN_IDLE = 1'b0,
        SCAN_RUN  = 1'b1
    } scan_state_t;

endpackage

`default_nettype wire

// *** design/fault_detect_filter.sv ***
// Fault detection, latching and totalizer filtering for a multi-cell monitor.
// Comparator results arrive as asynchronous pins; the host uses a strobe register port.
`timescale 1ns/100ps
`default_nettype none

module fault_detect_filter
    import fault_detect_pkg::*;
#(
    parameter int unsigned N_CELLS          = 12,
    parameter int unsigned SCAN_BASE_CYCLES = SCAN_BASE_CYC
) (
    input  wire logic               ref_clk,
    input  wire logic               rstn,
    input  wire logic [3:0]         reg_addr,
    input  wire logic [15:0]        reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output var  logic [15:0]        reg_rdata,
    input  wire logic [2:0]         rail_out_of_window,
    input  wire logic               slow_osc,
    input  wire logic [N_CELLS-1:0] cell_ov_cmp,
    input  wire logic [N_CELLS-1:0] cell_uv_cmp,
    input  wire logic [N_CELLS-1:0] cell_ot_cmp,
    input  wire logic [N_CELLS-1:0] cell_ow_cmp,
    input  wire logic               open_vbat_cmp,
    input  wire logic               open_vss_cmp,
    output var  logic               alarm,
    output var  logic               cont_scan_active
);

    localparam int unsigned FILT_N = 2 * N_CELLS + 2;
    localparam int unsigned SYNC_W = 4 * N_CELLS + 6;

    // Run length for a 3-bit code
    function automatic logic [7:0] tot_target(input logic [2:0] code);
        tot_target = 8'h01 << code;
    endfunction

    // Interval in cycles for a 4-bit code, clipped at code SCAN_CODE_MAX (12)
    function automatic logic [31:0] scan_cycles(input logic [3:0] code);
        logic [3:0] c;
        c = (code > 4'(SCAN_CODE_MAX)) ? 4'(SCAN_CODE_MAX) : code;
        scan_cycles = 32'(SCAN_BASE_CYCLES) << c;
    endfunction

    logic [SYNC_W-1:0]  sync1_q;
    logic [SYNC_W-1:0]  sync2_q;
    logic               osc_prev_q;
    logic [SETUP_W-1:0] setup_q;
    logic [7:0]         osc_lo_q;
    logic [7:0]         osc_hi_q;
    logic [N_CELLS-1:0] ov_q;
    logic [N_CELLS-1:0] uv_q;
    logic [N_CELLS-1:0] ot_q;
    logic [N_CELLS-1:0] ow_q;
    logic               vbat_q;
    logic               vss_q;
    logic               osc_q;
    logic               reg_q;
    logic [7:0]         status_prev_q;
    logic [7:0]         tot_q [FILT_N];
    logic [FILT_N-1:0]  hit_q;
    logic [15:0]        osc_win_q;
    logic [7:0]         osc_edges_q;
    logic [31:0]        int_cnt_q;
    scan_state_t        scan_q;
    logic               cmd_volt_q;
    logic               cmd_meas_q;
    logic               cmd_temp_q;
    logic               cmd_wire_q;

    // Two-stage synchronisers for all comparator pins
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            sync1_q <= '0;
            sync2_q <= '0;
        end
        else
        begin
            sync1_q <= {open_vss_cmp, open_vbat_cmp, slow_osc, rail_out_of_window,
                        cell_ow_cmp, cell_ot_cmp, cell_uv_cmp, cell_ov_cmp};
            sync2_q <= sync1_q;
        end
    end

    // Synchronised comparator fields
    wire logic [N_CELLS-1:0] ov_s   = sync2_q[N_CELLS-1:0];
    wire logic [N_CELLS-1:0] uv_s   = sync2_q[2*N_CELLS-1:N_CELLS];
    wire logic [N_CELLS-1:0] ot_s   = sync2_q[3*N_CELLS-1:2*N_CELLS];
    wire logic [N_CELLS-1:0] ow_s   = sync2_q[4*N_CELLS-1:3*N_CELLS];
    wire logic [2:0]         rail_s = sync2_q[4*N_CELLS+2:4*N_CELLS];
    wire logic               osc_s  = sync2_q[4*N_CELLS+3];
    wire logic               vbat_s = sync2_q[4*N_CELLS+4];
    wire logic               vss_s  = sync2_q[4*N_CELLS+5];

    // Register port decode
    wire logic wr_setup  = reg_wr && (reg_addr == ADDR_FAULT_SETUP);
    wire logic wr_cmd    = reg_wr && (reg_addr == ADDR_SCAN_CMD);
    wire logic wr_status = reg_wr && (reg_addr == ADDR_STATUS);
    wire logic wr_osc    = reg_wr && (reg_addr == ADDR_OSC_LIMITS);
    wire logic [7:0] st_clr = wr_status ? reg_wdata[7:0] : 8'h00;

    // Setup fields
    wire logic [3:0] scan_sel = setup_q[SCAN_SEL_LSB +: 4];
    wire logic       wire_sel = setup_q[WIRE_SEL_BIT];
    wire logic [2:0] tot_sel  = setup_q[TOT_SEL_LSB +: 3];
    wire logic [7:0] target   = tot_target(tot_sel);

    // Continuous interval tick
    wire logic cont_tick = (scan_q == SCAN_RUN) && (int_cnt_q == 32'h0000_0000);

    // Sample strobes; outside a scan only the rail and oscillator checks are sampled
    wire logic volt_strb = cmd_volt_q || cont_tick;
    wire logic meas_strb = cmd_meas_q;
    wire logic temp_strb = cmd_temp_q || (cont_tick && wire_sel);
    wire logic wire_strb = cmd_wire_q || cont_tick;
    wire logic cell_strb = volt_strb || meas_strb;

    // Status image and filter clear on any change
    wire logic [7:0] status_w = {reg_q, osc_q, vss_q, vbat_q,
                                 |ow_q, |ot_q, |uv_q, |ov_q};
    wire logic filt_clr = (status_w != status_prev_q);

    // Filter inputs and strobes, one per filtered test
    wire logic [FILT_N-1:0] filt_pos = {vss_s, vbat_s, uv_s, ov_s};
    wire logic [FILT_N-1:0] filt_stb = {{2{volt_strb}}, {(2*N_CELLS){cell_strb}}};

    // Oscillator window end and edge detection
    wire logic osc_edge    = osc_s && !osc_prev_q;
    wire logic osc_win_end = (osc_win_q == 16'(OSC_WIN_CYC - 1));
    wire logic osc_bad     = (osc_edges_q < osc_lo_q) || (osc_edges_q > osc_hi_q);

    // Read multiplexer
    logic [15:0] rd_mux;
    always_comb
    begin
        rd_mux = 16'h0000;
        case (reg_addr)
            ADDR_FAULT_SETUP: rd_mux = 16'(setup_q);
            ADDR_SCAN_CMD:    rd_mux = {15'h0000, scan_q == SCAN_RUN};
            ADDR_STATUS:      rd_mux = {8'h00, status_w};
            ADDR_OV_BITS:     rd_mux = 16'(ov_q);
            ADDR_UV_BITS:     rd_mux = 16'(uv_q);
            ADDR_OT_BITS:     rd_mux = 16'(ot_q);
            ADDR_OW_BITS:     rd_mux = 16'(ow_q);
            ADDR_OSC_LIMITS:  rd_mux = {osc_hi_q, osc_lo_q};
            default:          rd_mux = 16'h0000;
        endcase
    end

    // Configuration registers and one-shot scan commands
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            setup_q    <= SETUP_RESET;
            osc_lo_q   <= OSC_LO_RESET;
            osc_hi_q   <= OSC_HI_RESET;
            cmd_volt_q <= 1'b0;
            cmd_meas_q <= 1'b0;
            cmd_temp_q <= 1'b0;
            cmd_wire_q <= 1'b0;
            reg_rdata  <= 16'h0000;
        end
        else
        begin
            if (wr_setup)
                setup_q <= reg_wdata[SETUP_W-1:0];
            if (wr_osc)
                {osc_hi_q, osc_lo_q} <= reg_wdata;
            cmd_volt_q <= wr_cmd && (reg_wdata[CMD_SCAN_VOLT] || reg_wdata[CMD_SCAN_ALL]);
            cmd_meas_q <= wr_cmd && reg_wdata[CMD_MEASURE];
            cmd_temp_q <= wr_cmd && (reg_wdata[CMD_SCAN_TEMP] || reg_wdata[CMD_SCAN_ALL]);
            cmd_wire_q <= wr_cmd && (reg_wdata[CMD_SCAN_WIRE] || reg_wdata[CMD_SCAN_ALL]);
            reg_rdata  <= reg_rd ? rd_mux : 16'h0000;
        end
    end

    // Continuous scan sequencer and interval timer
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            scan_q    <= SCAN_IDLE;
            int_cnt_q <= 32'h0000_0000;
        end
        else
        begin
            case (scan_q)
                SCAN_IDLE:
                begin
                    // Preload a full interval so the first sample ends it
                    int_cnt_q <= scan_cycles(scan_sel) - 32'h0000_0001;
                    if (wr_cmd && reg_wdata[CMD_CONT_GO] && !reg_wdata[CMD_CONT_STOP])
                        scan_q <= SCAN_RUN;
                end
                SCAN_RUN:
                begin
                    if (wr_cmd && reg_wdata[CMD_CONT_STOP])
                        scan_q <= SCAN_IDLE;
                    if (cont_tick)
                        int_cnt_q <= scan_cycles(scan_sel) - 32'h0000_0001;
                    else
                        int_cnt_q <= int_cnt_q - 32'h0000_0001;
                end
                default:
                    scan_q <= SCAN_IDLE;
            endcase
        end
    end

    // Oscillator cross-check: slow edges per fast-clock window
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            osc_prev_q  <= 1'b0;
            osc_win_q   <= 16'h0000;
            osc_edges_q <= 8'h00;
        end
        else
        begin
            osc_prev_q <= osc_s;
            osc_win_q  <= osc_win_end ? 16'h0000 : osc_win_q + 16'h0001;
            if (osc_win_end)
                osc_edges_q <= 8'h00;
            else if (osc_edge && (osc_edges_q != 8'hFF))
                osc_edges_q <= osc_edges_q + 8'h01;
        end
    end

    // Totalizer filters, one per cell OV and UV test and one each for open VBAT and VSS
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            for (int i = 0; i < FILT_N; i++)
                tot_q[i] <= 8'h00;
            hit_q <= '0;
        end
        else
        begin
            for (int i = 0; i < FILT_N; i++)
            begin
                hit_q[i] <= 1'b0;
                if (filt_clr)
                    tot_q[i] <= 8'h00;
                else if (filt_stb[i] && !filt_pos[i])
                    tot_q[i] <= 8'h00;
                else if (filt_stb[i])
                begin
                    if (tot_q[i] < target)
                        tot_q[i] <= tot_q[i] + 8'h01;
                    else
                        tot_q[i] <= target;
                    if (tot_q[i] + 8'h01 >= target)
                        hit_q[i] <= 1'b1;
                end
            end
        end
    end

    // Fault latches: set wins over a host clear
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            ov_q   <= '0;
            uv_q   <= '0;
            ot_q   <= '0;
            ow_q   <= '0;
            vbat_q <= 1'b0;
            vss_q  <= 1'b0;
            osc_q  <= 1'b0;
            reg_q  <= 1'b0;
        end
        else
        begin
            ov_q   <= (st_clr[ST_OV] ? '0 : ov_q) | hit_q[N_CELLS-1:0];
            uv_q   <= (st_clr[ST_UV] ? '0 : uv_q) | hit_q[2*N_CELLS-1:N_CELLS];
            ot_q   <= (st_clr[ST_OT] ? '0 : ot_q) | (temp_strb ? ot_s : '0);
            ow_q   <= (st_clr[ST_OW] ? '0 : ow_q) | (wire_strb ? ow_s : '0);
            vbat_q <= (vbat_q && !st_clr[ST_VBAT]) || hit_q[2*N_CELLS];
            vss_q  <= (vss_q && !st_clr[ST_VSS]) || hit_q[2*N_CELLS+1];
            osc_q  <= (osc_q && !st_clr[ST_OSC]) || (osc_win_end && osc_bad);
            reg_q  <= (reg_q && !st_clr[ST_REG]) || (rail_s != 3'b000);
        end
    end

    // Alarm and status history
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            status_prev_q    <= 8'h00;
            alarm            <= 1'b0;
            cont_scan_active <= 1'b0;
        end
        else
        begin
            status_prev_q    <= status_w;
            alarm            <= (status_w != 8'h00);
            cont_scan_active <= (scan_q == SCAN_RUN);
        end
    end

    sequence s_rail_fault;
        rail_s != 3'b000;
    endsequence

    sequence s_supply_alarm;
        ##1 reg_q ##1 alarm;
    endsequence

    property p_supply_alarm;
        @(posedge ref_clk) disable iff (!rstn)
        s_rail_fault |-> s_supply_alarm;
    endproperty
    a_supply_alarm: assert property (p_supply_alarm)
        else $error("supply fault did not reach alarm");

    property p_osc_alarm;
        @(posedge ref_clk) disable iff (!rstn)
        (osc_win_end && osc_bad) |=> osc_q ##1 alarm;
    endproperty
    a_osc_alarm: assert property (p_osc_alarm)
        else $error("oscillator fault did not reach alarm");

    property p_no_idle_sample;
        @(posedge ref_clk) disable iff (!rstn)
        (!cell_strb && !filt_clr) |=> (hit_q == '0);
    endproperty
    a_no_idle_sample: assert property (p_no_idle_sample)
        else $error("filter hit without a scan");

    property p_single_sample;
        @(posedge ref_clk) disable iff (!rstn)
        (tot_sel == 3'b000 && volt_strb && vbat_s && !filt_clr) |=> ##1 vbat_q;
    endproperty
    a_single_sample: assert property (p_single_sample)
        else $error("one-sample run did not set open battery");

    property p_neg_clear;
        @(posedge ref_clk) disable iff (!rstn)
        (cell_strb && !ov_s[0]) |=> (tot_q[0] == 8'h00);
    endproperty
    a_neg_clear: assert property (p_neg_clear)
        else $error("negative sample left count");

    property p_clear_all;
        @(posedge ref_clk) disable iff (!rstn)
        filt_clr |=> (tot_q[0] == 8'h00) && (tot_q[FILT_N-1] == 8'h00);
    endproperty
    a_clear_all: assert property (p_clear_all)
        else $error("status change did not clear filters");

    property p_hold;
        @(posedge ref_clk) disable iff (!rstn)
        (ov_q[0] && !st_clr[ST_OV]) |=> ov_q[0];
    endproperty
    a_hold: assert property (p_hold)
        else $error("fault bit cleared without host write");

    property p_saturate;
        @(posedge ref_clk) disable iff (!rstn)
        (filt_stb[0] && !filt_clr) ##1 $stable(tot_sel) |-> (tot_q[0] <= target);
    endproperty
    a_saturate: assert property (p_saturate)
        else $error("count passed run length");

    property p_cont_sample;
        @(posedge ref_clk) disable iff (!rstn)
        cont_tick |-> volt_strb ##1 (int_cnt_q == scan_cycles($past(scan_sel)) - 32'h1);
    endproperty
    a_cont_sample: assert property (p_cont_sample)
        else $error("continuous tick wrong");

    property p_group_alarm;
        @(posedge ref_clk) disable iff (!rstn)
        $rose(|ov_q) |=> alarm && status_w[ST_OV];
    endproperty
    a_group_alarm: assert property (p_group_alarm)
        else $error("cell fault did not reach summary and alarm");

endmodule

`default_nettype wire

// *** testbench/host_model.sv ***
// Host controller model driving the register port of the fault unit.
// Assumes ref_clk is the design clock and read data stand one cycle after the strobe.
`timescale 1ns/100ps
`default_nettype none

module host_model
    import fault_detect_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic [15:0] reg_rdata,
    output var  logic [3:0]  reg_addr,
    output var  logic [15:0] reg_wdata,
    output var  logic        reg_wr,
    output var  logic        reg_rd
);
    // Idle bus at time zero
    initial
    begin
        reg_addr  = 4'h0;
        reg_wdata = 16'h0000;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end

    // One-cycle write strobe
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    endtask

    // One-cycle read strobe, data taken in the following cycle
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    // One-shot scan, resent by the caller for each new check
    task automatic scan(input int unsigned b);
        wr(ADDR_SCAN_CMD, 16'(1 << b));
        repeat (6) @(posedge ref_clk);
    endtask

    // Rewrite status bits to clear latched faults
    task automatic clear(input logic [15:0] bits);
        wr(ADDR_STATUS, bits);
        repeat (3) @(posedge ref_clk);
    endtask
endmodule

`default_nettype wire

// *** testbench/test_fault_detect_filter.sv ***
// Self-checking bench for the fault detection and filtering unit.
// Assumes a shortened scan base of 20 cycles and the host model on the register port.
`timescale 1ns/100ps
`default_nettype none

module test_fault_detect_filter
    import fault_detect_pkg::*;
;
    localparam int unsigned NC   = 12;
    localparam int unsigned BASE = 20;

    logic          ref_clk     = 1'b0;
    logic          rstn        = 1'b0;
    logic [3:0]    reg_addr;
    logic [15:0]   reg_wdata;
    logic          reg_wr;
    logic          reg_rd;
    logic [15:0]   reg_rdata;
    logic [2:0]    rail        = 3'h0;
    logic          slow_osc    = 1'b0;
    logic          osc_run     = 1'b1;
    logic [4:0]    osc_div     = 5'h00;
    logic [NC-1:0] ov          = '0;
    logic [NC-1:0] uv          = '0;
    logic [NC-1:0] ot          = '0;
    logic [NC-1:0] ow          = '0;
    logic          vbat        = 1'b0;
    logic          vss         = 1'b0;
    logic          alarm;
    logic          cont_scan_active;
    logic [15:0]   rv;
    int            miscompares = 0;
    int            check_count = 0;

    fault_detect_filter #(
        .N_CELLS          (NC),
        .SCAN_BASE_CYCLES (BASE)
    ) u_fault_detect_filter (
        .ref_clk            (ref_clk),
        .rstn               (rstn),
        .reg_addr           (reg_addr),
        .reg_wdata          (reg_wdata),
        .reg_wr             (reg_wr),
        .reg_rd             (reg_rd),
        .reg_rdata          (reg_rdata),
        .rail_out_of_window (rail),
        .slow_osc           (slow_osc),
        .cell_ov_cmp        (ov),
        .cell_uv_cmp        (uv),
        .cell_ot_cmp        (ot),
        .cell_ow_cmp        (ow),
        .open_vbat_cmp      (vbat),
        .open_vss_cmp       (vss),
        .alarm              (alarm),
        .cont_scan_active   (cont_scan_active)
    );

    host_model u_host_model (
        .ref_clk   (ref_clk),
        .reg_rdata (reg_rdata),
        .reg_addr  (reg_addr),
        .reg_wdata (reg_wdata),
        .reg_wr    (reg_wr),
        .reg_rd    (reg_rd)
    );

    // 20 MHz clock
    always #25 ref_clk = ~ref_clk;

    // Slow oscillator, about 62 rising edges per check window
    always @(posedge ref_clk)
    begin
        osc_div  <= osc_div + 5'h01;
        slow_osc <= osc_run & osc_div[4];
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR %0t: seen %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rchk(input logic [3:0] a, input logic [15:0] exp);
        u_host_model.rd(a, rv);
        check(rv, exp);
    endtask

    // Bounded wait for the alarm output
    task automatic wait_alarm(input int lim, output int n);
        n = 0;
        check_count++;
        while (alarm !== 1'b1)
        begin
            @(posedge ref_clk);
            #1;
            n++;
            if (n > lim)
            begin
                miscompares++;
                $display("ERROR %0t: alarm never came", $time);
                tally_and_finish();
            end
        end
    endtask

    // Drop the cell, VBAT and VSS comparators (rail left as is) and let the synchronisers settle
    task automatic quiet();
        @(posedge ref_clk);
        ov   <= '0;
        uv   <= '0;
        ot   <= '0;
        ow   <= '0;
        vbat <= 1'b0;
        vss  <= 1'b0;
        repeat (4) @(posedge ref_clk);
    endtask

    // Scan, check latched bits and alarm, then clear and check they went
    task automatic shot(input int unsigned c, input logic [3:0] a,
                        input logic [15:0] st, input logic [15:0] bits);
        repeat (4) @(posedge ref_clk);
        u_host_model.scan(c);
        quiet();
        rchk(ADDR_STATUS, st);
        rchk(a, bits);
        check({15'h0, alarm}, 16'h0001);
        u_host_model.clear(st);
        rchk(ADDR_STATUS, 16'h0000);
        rchk(a, 16'h0000);
    endtask

    task automatic t_regs();
        check({14'h0, alarm, cont_scan_active}, 16'h0000);
        rchk(ADDR_FAULT_SETUP, 16'(SETUP_RESET));
        rchk(ADDR_OSC_LIMITS, {OSC_HI_RESET, OSC_LO_RESET});
        rchk(4'h8, 16'h0000);
        u_host_model.wr(ADDR_FAULT_SETUP, 16'hFFFF);
        rchk(ADDR_FAULT_SETUP, 16'h1FFF);
        u_host_model.wr(4'h9, 16'hFFFF);
        rchk(4'h9, 16'h0000);
        u_host_model.wr(ADDR_FAULT_SETUP, 16'h0000);
    endtask

    task automatic t_scan();
        @(posedge ref_clk);
        ov   <= 12'h008;
        vbat <= 1'b1;
        vss  <= 1'b1;
        repeat (20) @(posedge ref_clk);
        rchk(ADDR_STATUS, 16'h0000);
        shot(CMD_SCAN_VOLT, ADDR_OV_BITS, 16'h0031, 16'h0008);
        uv <= 12'h001;
        shot(CMD_MEASURE, ADDR_UV_BITS, 16'h0002, 16'h0001);
        ot <= 12'h080;
        shot(CMD_SCAN_TEMP, ADDR_OT_BITS, 16'h0004, 16'h0080);
        ow <= 12'h002;
        shot(CMD_SCAN_WIRE, ADDR_OW_BITS, 16'h0008, 16'h0002);
        ot <= 12'h100;
        shot(CMD_SCAN_ALL, ADDR_OT_BITS, 16'h0004, 16'h0100);
    endtask

    // Every run-length code; cell 1 breaks its run on the last sample
    task automatic t_filter();
        for (int k = 0; k < 8; k++)
        begin
            u_host_model.wr(ADDR_FAULT_SETUP, 16'(k << 5));
            @(posedge ref_clk);
            ov <= 12'h003;
            repeat ((1 << k) - 1) u_host_model.scan(CMD_SCAN_VOLT);
            rchk(ADDR_STATUS, 16'h0000);
            @(posedge ref_clk);
            ov <= 12'h001;
            shot(CMD_SCAN_VOLT, ADDR_OV_BITS, 16'h0001, 16'h0001);
        end
    endtask

    task automatic t_clear();
        u_host_model.wr(ADDR_FAULT_SETUP, 16'h0020);
        @(posedge ref_clk);
        ov <= 12'h001;
        u_host_model.scan(CMD_SCAN_VOLT);
        quiet();
        u_host_model.scan(CMD_SCAN_VOLT);
        ov <= 12'h001;
        u_host_model.scan(CMD_SCAN_VOLT);
        rchk(ADDR_STATUS, 16'h0000);
        ow <= 12'h010;
        u_host_model.scan(CMD_SCAN_WIRE);
        u_host_model.scan(CMD_SCAN_VOLT);
        rchk(ADDR_STATUS, 16'h0008);
        shot(CMD_SCAN_VOLT, ADDR_OV_BITS, 16'h0009, 16'h0001);
    endtask

    // Continuous scan at three interval codes, run length 2
    task automatic t_cont();
        int n;
        for (int k = 0; k < 3; k++)
        begin
            u_host_model.wr(ADDR_FAULT_SETUP, 16'(32'h20 | k));
            @(posedge ref_clk);
            ov <= 12'h004;
            repeat (4) @(posedge ref_clk);
            u_host_model.wr(ADDR_SCAN_CMD, 16'h0020);
            wait_alarm(400, n);
            check(16'((n >= (BASE << (k + 1))) && (n <= (BASE << (k + 1)) + 4)), 16'h0001);
            check({15'h0, cont_scan_active}, 16'h0001);
            repeat (100) @(posedge ref_clk);
            rchk(ADDR_STATUS, 16'h0001);
            u_host_model.wr(ADDR_SCAN_CMD, 16'h0040);
            quiet();
            u_host_model.clear(16'h0001);
            rchk(ADDR_SCAN_CMD, 16'h0000);
            rchk(ADDR_STATUS, 16'h0000);
        end
    endtask

    task automatic t_supply();
        int n;
        for (int r = 0; r < 3; r++)
        begin
            @(posedge ref_clk);
            rail <= 3'(1 << r);
            wait_alarm(10, n);
            @(posedge ref_clk);
            rail <= 3'h0;
            repeat (6) @(posedge ref_clk);
            rchk(ADDR_STATUS, 16'h0080);
            u_host_model.clear(16'h0080);
            rchk(ADDR_STATUS, 16'h0000);
        end
    endtask

    task automatic t_osc();
        int n;
        @(posedge ref_clk);
        osc_run <= 1'b0;
        wait_alarm(4100, n);
        rchk(ADDR_STATUS, 16'h0040);
        @(posedge ref_clk);
        osc_run <= 1'b1;
        repeat (4100) @(posedge ref_clk);
        u_host_model.clear(16'h0040);
        rchk(ADDR_STATUS, 16'h0000);
        // Upper limit below the real edge count
        u_host_model.wr(ADDR_OSC_LIMITS, 16'h1001);
        wait_alarm(4100, n);
        rchk(ADDR_STATUS, 16'h0040);
        u_host_model.wr(ADDR_OSC_LIMITS, {OSC_HI_RESET, OSC_LO_RESET});
        repeat (4100) @(posedge ref_clk);
        u_host_model.clear(16'h0040);
        rchk(ADDR_STATUS, 16'h0000);
    endtask

    // Main sequence
    initial
    begin
        repeat (6) @(posedge ref_clk);
        rstn <= 1'b1;
        @(posedge ref_clk);
        t_regs();
        t_scan();
        t_filter();
        t_clear();
        t_cont();
        t_supply();
        t_osc();
        tally_and_finish();
    end

    // Overall run limit
    initial
    begin
        repeat (60000) @(posedge ref_clk);
        miscompares++;
        $display("ERROR %0t: run limit reached", $time);
        tally_and_finish();
    end
endmodule

`default_nettype wire
